// ### verilog/exposure_timing_pkg.sv
// =============================================================
// Shared constants for exposure and frame timing
package exposure_timing_pkg;
   // Register addresses on the serial port (7-bit)
   localparam logic [6:0] ADDR_EXP_HIGH = 7'h49;
   localparam logic [6:0] ADDR_EXP_LOW = 7'h4a;
   localparam logic [6:0] ADDR_FRAME_HIGH = 7'h4b;
   // Address byte: bit 7 set means write
   localparam int ADDR_WRITE_BIT = 7;
   localparam logic [2:0] SIO_LAST_BIT = 3'h7;
   // Values after reset
   localparam logic [15:0] EXP_RESET = 16'h0100;
   localparam logic [7:0] FRAME_HIGH_RESET = 8'h00;
   localparam logic [15:0] FRAME_CNT_RESET = 16'h0000;
   // Frame arithmetic
   localparam logic [16:0] FRAME_SPAN = 17'h10000;
   localparam logic [16:0] EXP_MARGIN = 17'h00d94;   // 3476 cycles
   localparam logic [15:0] EXP_MIN = 16'h0001;
   localparam int EXP_STEP_SHIFT = 4;                 // One sixteenth
   localparam logic [15:0] FRAME_LAST = 16'hffff;
   // Pixel scale and gain loop targets
   localparam logic [5:0] PIX_BLACK = 6'h00;
   localparam logic [5:0] PIX_WHITE = 6'h3f;
   localparam logic [5:0] MAXPIX_LO = 6'h35;          // 53
   localparam logic [5:0] MAXPIX_HI = 6'h39;          // 57
   localparam logic [14:0] PIX_SUM_HI = 15'h4bf0;     // 324 pixels x 60
   localparam logic [14:0] PIX_SUM_MAX = 15'h7fff;
   // Core clock rate, informational
   localparam int CORE_CLK_KHZ = 20000;
   // Serial state machine, Gray along address to data
   typedef enum logic [1:0] {
      SIO_ADDR = 2'b00,
      SIO_RDATA = 2'b01,
      SIO_WDATA = 2'b10
   } sio_state_t;
endpackage

// ### verilog/serial_reg_port.sv
`timescale 1ns/100ps
// =============================================================
// Two-wire serial register port, sampled on the core clock
module serial_reg_port
   import exposure_timing_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic sck_in,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_out,
   output logic [6:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [7:0] reg_rdata_in
);
   // =============================================================
   // Synchronisers; edges found between second and third stage
   logic sck_s1_r, sck_s2_r, sck_s3_r, sdio_s1_r, sdio_s2_r;
   logic sck_rise, sck_fall;
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
         sck_s3_r <= 1'b1;
         sdio_s1_r <= 1'b0;
         sdio_s2_r <= 1'b0;
      end else begin
         sck_s1_r <= sck_in;
         sck_s2_r <= sck_s1_r;
         sck_s3_r <= sck_s2_r;
         sdio_s1_r <= sdio_in;
         sdio_s2_r <= sdio_s1_r;
      end
   end
   assign sck_rise = sck_s2_r & ~sck_s3_r;
   assign sck_fall = ~sck_s2_r & sck_s3_r;

   // =============================================================
   // Shift state; host bits taken on rising, ours driven on falling
   sio_state_t state_r, state_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [6:0] addr_r, addr_nxt;
   logic oe_r, oe_nxt, wr_r, wr_nxt, rd_r, rd_nxt;
   always_comb begin
      state_nxt = state_r;
      bit_nxt = bit_r;
      shift_nxt = shift_r;
      addr_nxt = addr_r;
      oe_nxt = oe_r;
      wr_nxt = 1'b0;
      rd_nxt = 1'b0;
      case (state_r)
         SIO_ADDR: begin
            if (sck_rise) begin
               shift_nxt = {shift_r[6:0], sdio_s2_r};
               bit_nxt = bit_r + 3'h1;
               if (bit_r == SIO_LAST_BIT) begin
                  addr_nxt = {shift_r[5:0], sdio_s2_r};
                  if (shift_r[ADDR_WRITE_BIT - 1]) begin
                     state_nxt = SIO_WDATA;
                  end else begin
                     state_nxt = SIO_RDATA;
                     rd_nxt = 1'b1;
                  end
               end
            end
         end
         SIO_WDATA: begin
            if (sck_rise) begin
               shift_nxt = {shift_r[6:0], sdio_s2_r};
               bit_nxt = bit_r + 3'h1;
               if (bit_r == SIO_LAST_BIT) begin
                  wr_nxt = 1'b1;
                  state_nxt = SIO_ADDR;
               end
            end
         end
         SIO_RDATA: begin
            if (sck_fall) begin
               // First falling edge loads the answer captured after the strobe
               shift_nxt = oe_r ? {shift_r[6:0], 1'b0} : reg_rdata_in;
               oe_nxt = 1'b1;
            end else if (sck_rise && oe_r) begin
               bit_nxt = bit_r + 3'h1;
               if (bit_r == SIO_LAST_BIT) begin
                  oe_nxt = 1'b0;
                  state_nxt = SIO_ADDR;
               end
            end
         end
         default: begin
            state_nxt = SIO_ADDR;
            oe_nxt = 1'b0;
         end
      endcase
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= SIO_ADDR;
         bit_r <= 3'h0;
         shift_r <= 8'h00;
         addr_r <= 7'h00;
         oe_r <= 1'b0;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bit_r <= bit_nxt;
         shift_r <= shift_nxt;
         addr_r <= addr_nxt;
         oe_r <= oe_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end
   assign sdio_out = shift_r[7];
   assign sdio_oe_out = oe_r;
   assign reg_addr_out = addr_r;
   assign reg_wdata_out = shift_r;
   assign reg_wr_out = wr_r;
   assign reg_rd_out = rd_r;
endmodule

// ### verilog/exposure_timing.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RL1] Pixel intensities are six bits, 0 black up to 63 white.
// [RL2] Gain loop steers exposure so the brightest pixel sits in the mid fifties.
// [RL3] Exposure is sixteen bits of clock cycles, reset 0x0100, high then low byte.
// [RL4] Host reads the high byte then the low byte back to back.
// [RL5] Exposure may change once per frame from average and maximum pixel levels.
// [RL6] Each exposure change is plus or minus one sixteenth of its value; below sixteen the code steps by one count.
// [RL7] Exposure is capped at clocks per frame minus 3476; for frames of 3476 cycles or fewer the code caps it at one.
// [RL8] Frames are timed by a sixteen-bit up-counter ending on overflow.
// [RL9] Frame register holds the upper byte of the two's complement frame length.
// [RL10] Host may adapt frame rate to exposure above 1500 frames per second.
// [RL11] A new frame length takes effect only at the next frame boundary.
module exposure_timing
   import exposure_timing_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic sck_in,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_out,
   input wire logic pix_valid_in,
   input wire logic [5:0] pix_data_in,
   output logic led_ctl_out,
   output logic frame_end_out,
   output logic [15:0] exposure_out
);
   // =============================================================
   // Exposure ceiling for a given frame length byte
   function automatic logic [15:0] exp_cap(input logic [7:0] frame_high);
      logic [16:0] span;
      span = FRAME_SPAN - {1'b0, frame_high, 8'h00};
      if (span > EXP_MARGIN) begin
         exp_cap = 16'(span - EXP_MARGIN);        // [RL7]
      end else begin
         exp_cap = EXP_MIN;                       // Too short a frame to expose
      end
   endfunction

   logic [6:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr, reg_rd;
   logic [7:0] rdata_r, rdata_nxt, low_snap_r, low_snap_nxt;
   logic [7:0] frame_high_r, frame_high_nxt;
   logic [7:0] frame_act_r, frame_act_nxt;
   logic [15:0] frame_cnt_r, frame_cnt_nxt, elapsed_r, elapsed_nxt;
   logic [15:0] exp_r, exp_nxt, step_w;
   logic [5:0] max_pix_r, max_pix_nxt;
   logic [14:0] sum_r, sum_nxt;
   logic led_r, led_nxt, frame_end_r, frame_wrap;
   logic bright, dark;
   logic [16:0] exp_up;

   // =============================================================
   // Serial port front end
   serial_reg_port u_sio (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .sck_in(sck_in),
      .sdio_in(sdio_in),
      .sdio_out(sdio_out),
      .sdio_oe_out(sdio_oe_out),
      .reg_addr_out(reg_addr),
      .reg_wdata_out(reg_wdata),
      .reg_wr_out(reg_wr),
      .reg_rd_out(reg_rd),
      .reg_rdata_in(rdata_r)
   );

   // =============================================================
   // Register file; low byte is snapshotted when the high byte is read,
   // so a frame update between the two reads cannot tear the word
   always_comb begin
      rdata_nxt = rdata_r;
      low_snap_nxt = low_snap_r;
      frame_high_nxt = frame_high_r;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_EXP_HIGH: begin
               rdata_nxt = exp_r[15:8];               // [RL3]
               low_snap_nxt = exp_r[7:0];             // [RL4]
            end
            ADDR_EXP_LOW: rdata_nxt = low_snap_r;     // [RL3]
            ADDR_FRAME_HIGH: rdata_nxt = frame_high_r;
            default: rdata_nxt = 8'h00;               // Unmapped reads as zero
         endcase
      end
      if (reg_wr && reg_addr == ADDR_FRAME_HIGH) begin
         frame_high_nxt = reg_wdata;                  // [RL9]
      end
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_r <= 8'h00;
         low_snap_r <= EXP_RESET[7:0];
         frame_high_r <= FRAME_HIGH_RESET;
      end else begin
         rdata_r <= rdata_nxt;
         low_snap_r <= low_snap_nxt;
         frame_high_r <= frame_high_nxt;
      end
   end

   // =============================================================
   // Frame timer and LED shutter window
   assign frame_wrap = frame_cnt_r == FRAME_LAST;     // [RL8]
   always_comb begin
      frame_act_nxt = frame_act_r;
      if (frame_wrap) begin
         frame_act_nxt = frame_high_r;                // [RL11]
         frame_cnt_nxt = {frame_high_r, 8'h00};       // [RL9]
         elapsed_nxt = 16'h0000;
      end else begin
         frame_cnt_nxt = frame_cnt_r + 16'h0001;      // [RL8]
         elapsed_nxt = elapsed_r + 16'h0001;
      end
      led_nxt = elapsed_nxt < exp_nxt;
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         frame_act_r <= FRAME_HIGH_RESET;
         frame_cnt_r <= FRAME_CNT_RESET;
         elapsed_r <= 16'h0000;
         led_r <= 1'b0;
         frame_end_r <= 1'b0;
      end else begin
         frame_act_r <= frame_act_nxt;
         frame_cnt_r <= frame_cnt_nxt;
         elapsed_r <= elapsed_nxt;
         led_r <= led_nxt;
         frame_end_r <= frame_wrap;
      end
   end

   // =============================================================
   // Per-frame pixel statistics; a pixel in the wrap cycle opens the next frame
   always_comb begin
      if (frame_wrap) begin
         max_pix_nxt = pix_valid_in ? pix_data_in : PIX_BLACK;
         sum_nxt = pix_valid_in ? {9'h000, pix_data_in} : 15'h0000;
      end else begin
         max_pix_nxt = (pix_valid_in && pix_data_in > max_pix_r) ? pix_data_in
                                                                 : max_pix_r; // [RL1]
         // Saturate rather than wrap if the imager sends too many pixels
         sum_nxt = sum_r;
         if (pix_valid_in) begin
            sum_nxt = (sum_r > PIX_SUM_MAX - {9'h000, pix_data_in}) ? PIX_SUM_MAX
                      : sum_r + {9'h000, pix_data_in};
         end
      end
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         max_pix_r <= PIX_BLACK;
         sum_r <= 15'h0000;
      end else begin
         max_pix_r <= max_pix_nxt;
         sum_r <= sum_nxt;
      end
   end

   // =============================================================
   // Gain loop: one step per frame; small values still move by one count
   assign step_w = (exp_r >> EXP_STEP_SHIFT) == 16'h0000 ? 16'h0001
                   : (exp_r >> EXP_STEP_SHIFT);                               // [RL6]
   assign bright = max_pix_r > MAXPIX_HI || sum_r > PIX_SUM_HI;               // [RL5]
   assign dark = max_pix_r < MAXPIX_LO;                                       // [RL2]
   assign exp_up = {1'b0, exp_r} + {1'b0, step_w};
   always_comb begin
      exp_nxt = exp_r;
      if (frame_wrap) begin
         if (bright) begin
            exp_nxt = (exp_r > step_w) ? exp_r - step_w : EXP_MIN;            // [RL6]
         end else if (dark) begin
            exp_nxt = exp_up[16] ? 16'hffff : exp_up[15:0];                   // [RL2]
         end
         // Ceiling follows the length of the frame about to start
         if (exp_nxt > exp_cap(frame_high_r)) begin
            exp_nxt = exp_cap(frame_high_r);                                  // [RL7]
         end
      end
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         exp_r <= EXP_RESET;                                                  // [RL3]
      end else begin
         exp_r <= exp_nxt;
      end
   end

   assign led_ctl_out = led_r;
   assign frame_end_out = frame_end_r;
   assign exposure_out = exp_r;

   // =============================================================
   // Checks
   a_exp_reset: assert property (@(posedge core_clk_in)                       // [RL3]
      $rose(reset_n_in) |-> exp_r == EXP_RESET)
      else $error("exposure not at reset value");
   a_exp_per_frame: assert property (@(posedge core_clk_in)                   // [RL5]
      disable iff (!reset_n_in) $changed(exp_r) |-> $past(frame_wrap))
      else $error("exposure changed outside frame boundary");
   a_exp_step: assert property (@(posedge core_clk_in)                        // [RL6]
      disable iff (!reset_n_in)
      ($changed(exp_r) && exp_r != exp_cap(frame_act_r) && exp_r != EXP_MIN
       && exp_r != 16'hffff)
      |-> (exp_r == $past(exp_r) + $past(step_w) || exp_r == $past(exp_r) - $past(step_w)))
      else $error("exposure step not one sixteenth");
   a_exp_cap: assert property (@(posedge core_clk_in)                         // [RL7]
      disable iff (!reset_n_in) $past(frame_wrap) |-> exp_r <= exp_cap(frame_act_r))
      else $error("exposure above frame ceiling");
   a_agc_bright: assert property (@(posedge core_clk_in)                      // [RL2]
      disable iff (!reset_n_in) (frame_wrap && max_pix_r > MAXPIX_HI) |=> exp_r <= $past(exp_r))
      else $error("exposure rose on bright frame");
   a_agc_dark: assert property (@(posedge core_clk_in)                        // [RL2]
      disable iff (!reset_n_in)
      (frame_wrap && dark && sum_r <= PIX_SUM_HI && exp_r < exp_cap(frame_high_r))
      |=> exp_r > $past(exp_r))
      else $error("exposure did not rise on dark frame");
   // Sampled reset in the antecedent: the release edge itself still holds the counter
   a_frame_count_up: assert property (@(posedge core_clk_in)                  // [RL8]
      disable iff (!reset_n_in) (reset_n_in && !frame_wrap)
      |=> frame_cnt_r == $past(frame_cnt_r) + 16'h0001)
      else $error("frame counter not counting up");
   a_frame_reload: assert property (@(posedge core_clk_in)                    // [RL9]
      disable iff (!reset_n_in) frame_wrap |=> frame_cnt_r == {$past(frame_high_r), 8'h00}
      ##0 frame_end_out)
      else $error("frame counter reload wrong");
   a_frame_len_hold: assert property (@(posedge core_clk_in)                  // [RL11]
      disable iff (!reset_n_in) $changed(frame_act_r) |-> $past(frame_wrap))
      else $error("frame length changed mid frame");
   a_pix_max_range: assert property (@(posedge core_clk_in)                   // [RL1]
      disable iff (!reset_n_in) (pix_valid_in && !frame_wrap) |=> max_pix_r >= $past(pix_data_in))
      else $error("maximum pixel missed a sample");
   c_exp_down: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      frame_wrap && bright ##1 exp_r < $past(exp_r));
   c_exp_up: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      frame_wrap && dark ##1 exp_r > $past(exp_r));
   c_frame_len_write: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_wr && reg_addr == ADDR_FRAME_HIGH);
   c_exp_read: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd && reg_addr == ADDR_EXP_HIGH);
endmodule

// ### sim/host_model.sv
`timescale 1ns/100ps
// =============================================================
// Host controller model on the two-wire serial port
module host_model
   import exposure_timing_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sdio_wire_in,
   output logic sck_out,
   output logic sdio_drv_out,
   output logic sdio_en_out
);
   // Serial clock idles high, line released
   initial begin
      sck_out = 1'b1;
      sdio_drv_out = 1'b1;
      sdio_en_out = 1'b0;
   end

   // One half of the 400 ns serial clock, long enough for the synchronisers
   task automatic half();
      repeat (4) @(posedge core_clk_in);
   endtask

   // Byte out MSB first, data changed only while the clock is low
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sck_out <= 1'b0;
         sdio_drv_out <= b[i];
         sdio_en_out <= 1'b1;
         half();
         sck_out <= 1'b1;
         half();
      end
   endtask

   // Line released; each bit taken as the clock rises
   task automatic recv_byte(output logic [7:0] b);
      b = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         sck_out <= 1'b0;
         sdio_en_out <= 1'b0;
         half();
         b[i] = sdio_wire_in;
         sck_out <= 1'b1;
         half();
      end
      half(); // Idle high so the device lets go before the next address
   endtask

   // Write: address with the write bit set, then data
   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      send_byte({1'b1, a});
      send_byte(d);
      sdio_en_out <= 1'b0;
      half();
   endtask

   task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
      send_byte({1'b0, a});
      recv_byte(d);
   endtask

   // Exposure fetched high byte then low byte, nothing in between
   task automatic read_exposure(output logic [15:0] e);
      logic [7:0] hi;
      logic [7:0] lo;
      reg_read(ADDR_EXP_HIGH, hi);
      reg_read(ADDR_EXP_LOW, lo);
      e = {hi, lo};
   endtask
endmodule

// ### sim/test_exposure_timing.sv
`timescale 1ns/100ps
// =============================================================
// Self-checking bench for exposure and frame timing
module test_exposure_timing
   import exposure_timing_pkg::*;
;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic sck;
   logic host_d;
   logic host_en;
   logic sdio_wire;
   logic sdio_out;
   logic sdio_oe;
   logic pix_valid = 1'b0;
   logic [5:0] pix_data = 6'h00;
   logic led;
   logic frame_end;
   logic [15:0] exposure;
   int n_fail = 0;
   int check_count = 0;
   int n_frames = 0;
   int cyc = 0;
   int led_cnt = 0;
   int last_len = 0;
   int last_led = 0;
   logic [7:0] b;
   logic [15:0] e;
   // Per frame: pixel level, exposure in force, frame length in cycles
   logic [5:0] lvl [6] = '{6'h37, 6'h3f, 6'h00, 6'h00, 6'h3f, 6'h00};
   logic [15:0] exp_e [6] = '{16'h0100, 16'h0100, 16'h00f0, 16'h00ff, 16'h0001, 16'h0001};
   int len_e [6] = '{65536, 4096, 4096, 4096, 2048, 0};

   always #25 core_clk_in = ~core_clk_in;

   // Shared wire: device wins while enabled, pull-up when nobody drives
   assign sdio_wire = sdio_oe ? sdio_out : (host_en ? host_d : 1'b1);

   exposure_timing dut (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .sck_in(sck),
      .sdio_in(sdio_wire),
      .sdio_out(sdio_out),
      .sdio_oe_out(sdio_oe),
      .pix_valid_in(pix_valid),
      .pix_data_in(pix_data),
      .led_ctl_out(led),
      .frame_end_out(frame_end),
      .exposure_out(exposure)
   );

   host_model host (
      .core_clk_in(core_clk_in),
      .sdio_wire_in(sdio_wire),
      .sck_out(sck),
      .sdio_drv_out(host_d),
      .sdio_en_out(host_en)
   );

   // =============================================================
   // Frame monitor: frame length and shutter-on cycles per frame
   always @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         cyc = 0;
         led_cnt = 0;
      end else if (frame_end === 1'b1) begin
         last_len = cyc;
         last_led = led_cnt;
         cyc = 1;
         led_cnt = (led === 1'b1) ? 1 : 0;
         n_frames++;
      end else begin
         cyc++;
         led_cnt += (led === 1'b1) ? 1 : 0;
      end
   end

   // =============================================================
   // Checking and closing
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
      check_count++;
      if (seen !== expv) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, expv, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Bounded wait for the next frame boundary
   task automatic wait_frame();
      int n0;
      n0 = n_frames;
      for (int i = 0; i < 70000 && n_frames == n0; i++) begin
         @(posedge core_clk_in);
      end
      if (n_frames == n0) begin
         n_fail++;
         $display("unexpected frame boundary: none within limit");
         end_sim();
      end
   endtask

   // A short burst of pixels at one level, well clear of the wrap cycle
   task automatic pixels(input logic [5:0] v);
      repeat (4) begin
         pix_valid <= 1'b1;
         pix_data <= v;
         @(posedge core_clk_in);
      end
      pix_valid <= 1'b0;
   endtask

   // =============================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      @(posedge core_clk_in);
      check("exposure_out", exposure, 16'h0100);
      host.reg_read(ADDR_FRAME_HIGH, b);
      check("frame_length_high", {8'h00, b}, 16'h0000);
      host.read_exposure(e);
      check("exposure_count", e, 16'h0100);
      host.reg_read(7'h20, b);
      check("unmapped", {8'h00, b}, 16'h0000);
      // Read-only high byte must ignore a write
      host.reg_write(ADDR_EXP_HIGH, 8'h5a);
      host.read_exposure(e);
      check("exposure_count", e, 16'h0100);
      // Shorter frame, written mid-frame; the running frame is not cut
      host.reg_write(ADDR_FRAME_HIGH, 8'hf0);
      host.reg_read(ADDR_FRAME_HIGH, b);
      check("frame_length_high", {8'h00, b}, 16'h00f0);
      pixels(lvl[0]);
      for (int k = 1; k <= 5; k++) begin
         wait_frame();
         // Compared less one so that the full 65536-cycle first frame fits 16 bits
         check("frame cycles", 16'(last_len - 1), 16'(len_e[k - 1] - 1));
         // Frame zero starts in reset, which holds the shutter off for its first cycle
         check("shutter cycles", 16'(last_led), exp_e[k - 1] - 16'(k == 1));
         check("exposure_out", exposure, exp_e[k]);
         host.read_exposure(e);
         check("exposure_count", e, exp_e[k]);
         if (k == 3 && e < 16'h0100) begin
            // Short shutter, bright surface: host picks a faster frame
            // Span falls below the margin, so the cap is one: the next update must clip
            host.reg_write(ADDR_FRAME_HIGH, 8'hf8);
            host.reg_read(ADDR_FRAME_HIGH, b);
            check("frame_length_high", {8'h00, b}, 16'h00f8);
         end
         pixels(lvl[k]);
      end
      end_sim();
   end
endmodule
